// ==== host_access_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "host_port_consts.svh"

module host_access_port
    import host_port_pkg::*;
(
    // Clock and reset.
    input  wire logic       SYS_CLK,
    input  wire logic       SYS_RST,
    // Interface selection straps.
    input  wire logic       SERIAL_PARALLEL_SELECT,
    input  wire logic [1:0] HOST_TYPE_SELECT,
    // Shared chip select.
    input  wire logic       CS_N,
    // Serial port.
    input  wire logic       SCLK,
    input  wire logic       SERIAL_IN,
    output logic            SERIAL_OUT,
    output logic            SERIAL_OUT_OE,
    // Parallel port.
    input  wire logic [7:0] ADDR,
    input  wire logic       ADDR_LATCH,
    input  wire logic       READ_OR_DATA_STROBE_N,
    input  wire logic       WRITE_OR_DIRECTION,
    input  wire logic [7:0] DATA_IN,
    output logic [7:0]      DATA_OUT,
    output logic            DATA_OE,
    output logic            READY_N,
    // Register file side.
    output logic [7:0]      REG_ADDR,
    output logic [7:0]      REG_WDATA,
    output logic            REG_WR,
    output logic            REG_RD,
    input  wire logic [7:0] REG_RDATA,
    // Interrupt request from the register file and its pin.
    input  wire logic       INT_REQ,
    output logic            INT_N
);

    serial_link_if lnk ();

    logic [`SYNC_W-1:0] s1_r;
    logic [`SYNC_W-1:0] s2_r;
    logic [`SYNC_W-1:0] s3_r;

    // Every pin crosses two flops; a third stage only serves edge finding.
    wire [`SYNC_W-1:0] pins = {DATA_IN, ADDR, WRITE_OR_DIRECTION, ADDR_LATCH,
                               HOST_TYPE_SELECT, SERIAL_PARALLEL_SELECT,
                               SERIAL_IN, READ_OR_DATA_STROBE_N, SCLK, CS_N};

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s1_r <= `SYNC_RST;
            s2_r <= `SYNC_RST;
            s3_r <= `SYNC_RST;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Named views of the synchronised pins.
    wire        cs_n     = s2_r[0];
    wire        sclk     = s2_r[1];
    wire        strb_n   = s2_r[2];
    wire        serial_in      = s2_r[3];
    wire        ser_mode = s2_r[4];
    wire [1:0]  hts      = s2_r[6:5];
    wire        ale      = s2_r[7];
    wire        wr_dir   = s2_r[8];
    wire [7:0]  addr_in  = s2_r[16:9];
    wire [7:0]  data_in  = s2_r[24:17];
    wire        cs_rise  = s2_r[0] & ~s3_r[0];
    wire        ale_fall = ~s2_r[7] & s3_r[7];
    wire        strb_fal = ~s2_r[2] & s3_r[2];
    wire        wr_fall  = ~s2_r[8] & s3_r[8];

    // Mode decode; the separate-strobe mode reads the direction pin as a write strobe.
    wire sep_mode  = (hts == `HTS_SEP_STROBE);
    wire dir_mode  = (hts == `HTS_DATA_STROBE) | (hts == `HTS_SYNC_BUS);
    wire par_sel   = ~ser_mode & ~cs_n;
    wire sep_rd    = par_sel & sep_mode & strb_fal;
    wire sep_wr    = par_sel & sep_mode & wr_fall & strb_n;
    wire dir_go    = par_sel & dir_mode & strb_fal;
    wire start_rd  = sep_rd | (dir_go & wr_dir);
    wire start_wr  = sep_wr | (dir_go & ~wr_dir);
    wire strobe_up = sep_mode ? (strb_n & wr_dir) : strb_n;

    // Serial link hookup.
    assign lnk.cs_n      = cs_n | ~ser_mode;
    assign lnk.cs_rise   = cs_rise & ser_mode;
    assign lnk.sclk_rise = sclk & ~s3_r[1];
    assign lnk.sclk_fall = ~sclk & s3_r[1];
    assign lnk.serial_in       = serial_in;
    assign lnk.rd_data   = REG_RDATA;

    serial_frame_engine u_engine (
        .clk (SYS_CLK),
        .rst (SYS_RST),
        .lnk (lnk.engine)
    );

    par_state_e state_r;
    par_state_e state_nxt;
    byte_t      alat_r;
    logic       alat_vld_r;
    logic       is_rd_r;
    logic       rd_valid_r;

    // Address latch on the falling edge of the latch/address strobe pin, outside the synchronous bus mode.
    // If that pin is tied high, the live address bus is used instead.
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            alat_r     <= 8'h00;
            alat_vld_r <= 1'b0;
        end else if (ale_fall & ~hts[1]) begin
            alat_r     <= addr_in;
            alat_vld_r <= 1'b1;
        end else if (ale & strb_n & wr_dir) begin
            alat_vld_r <= 1'b0;
        end
    end

    wire [7:0] par_addr = (alat_vld_r & ~hts[1]) ? alat_r : addr_in;

    // Sequencer: issue, capture read data, then hold ready until the strobe ends.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            PAR_IDLE:    if (start_rd | start_wr) state_nxt = PAR_ISSUE;
            PAR_ISSUE:   state_nxt = PAR_CAPTURE;
            PAR_CAPTURE: state_nxt = PAR_DONE;
            PAR_DONE:    if (strobe_up | cs_n) state_nxt = PAR_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_r <= PAR_IDLE;
            is_rd_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r == PAR_IDLE) begin
                is_rd_r <= start_rd;
            end
        end
    end

    wire par_go = (state_r == PAR_IDLE) & (start_rd | start_wr);

    // Register file requests from whichever port is selected.
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            REG_ADDR   <= 8'h00;
            REG_WDATA  <= 8'h00;
            REG_RD     <= 1'b0;
            REG_WR     <= 1'b0;
            rd_valid_r <= 1'b0;
        end else begin
            REG_RD     <= (par_go & start_rd) | lnk.rd_req;
            REG_WR     <= (par_go & start_wr) | lnk.wr_req;
            rd_valid_r <= REG_RD;
            if (par_go) begin
                REG_ADDR  <= par_addr;
                REG_WDATA <= data_in;
            end else if (lnk.rd_req | lnk.wr_req) begin
                REG_ADDR  <= lnk.addr;
                REG_WDATA <= lnk.wdata;
            end
        end
    end

    assign lnk.rd_valid = rd_valid_r & ser_mode;

    // Parallel data bus and ready. Drive only while a read is being answered.
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            DATA_OUT <= 8'h00;
            DATA_OE  <= 1'b0;
            READY_N  <= 1'b1;
        end else begin
            if (state_r == PAR_CAPTURE) begin
                DATA_OUT <= REG_RDATA;
            end
            DATA_OE <= is_rd_r & (state_nxt == PAR_DONE);
            READY_N <= ~(state_nxt == PAR_DONE);
        end
    end

    // Serial output pins and the interrupt pin; status stays readable for polling.
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            SERIAL_OUT    <= 1'b0;
            SERIAL_OUT_OE <= 1'b0;
            INT_N         <= 1'b1;
        end else begin
            SERIAL_OUT    <= lnk.serial_out;
            SERIAL_OUT_OE <= lnk.sdo_oe & ~cs_n;
            INT_N         <= ~INT_REQ;
        end
    end

endmodule

`default_nettype wire

// ==== host_port_consts.svh ====
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH

// Serial frame layout, counted in rising serial clock edges.
`define SER_FRAME_LEN     5'd24
`define SER_ADDR_LEN      5'd8
`define SER_DATA_FIRST    5'd17
`define SER_DATA_LAST     5'd24

// Host type select codes.
`define HTS_SEP_STROBE    2'h0
`define HTS_DATA_STROBE   2'h1
`define HTS_SYNC_BUS      2'h3

// Widths and reset values.
`define REG_ADDR_W        8
`define REG_DATA_W        8
`define SYNC_W            25
`define SYNC_RST          25'h0000007

`endif

// ==== host_port_pkg.sv ====
package host_port_pkg;

    // Parallel access sequencer, Gray coded along the normal path.
    typedef enum logic [1:0] {
        PAR_IDLE    = 2'h0,
        PAR_ISSUE   = 2'h1,
        PAR_CAPTURE = 2'h3,
        PAR_DONE    = 2'h2
    } par_state_e;

    typedef logic [7:0] byte_t;

endpackage

// ==== serial_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// Carries the sampled serial pins to the frame engine and its requests back.
interface serial_link_if;
    logic       cs_n;
    logic       cs_rise;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       serial_in;
    logic       rd_valid;
    logic [7:0] rd_data;
    logic       rd_req;
    logic       wr_req;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       serial_out;
    logic       sdo_oe;

    modport engine (
        input  cs_n, cs_rise, sclk_rise, sclk_fall, serial_in, rd_valid, rd_data,
        output rd_req, wr_req, addr, wdata, serial_out, sdo_oe
    );
    modport core (
        output cs_n, cs_rise, sclk_rise, sclk_fall, serial_in, rd_valid, rd_data,
        input  rd_req, wr_req, addr, wdata, serial_out, sdo_oe
    );
endinterface

`default_nettype wire

// ==== serial_frame_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "host_port_consts.svh"

module serial_frame_engine
    import host_port_pkg::*;
(
    // Clock and reset.
    input  wire logic     clk,
    input  wire logic     rst,
    // Link to the core.
    serial_link_if.engine lnk
);

    logic [4:0]  cnt_r;
    logic [23:0] shift_r;
    logic        rw_r;
    byte_t       addr_r;
    byte_t       rbuf_r;
    logic        rd_req_r;
    logic        wr_req_r;
    logic        sdo_r;
    logic        sdo_oe_r;

    // Edge qualifiers for the frame.
    wire in_frame   = ~lnk.cs_n;
    wire take_bit   = in_frame & lnk.sclk_rise & (cnt_r < `SER_FRAME_LEN);
    wire hdr_done   = take_bit & (cnt_r == `SER_ADDR_LEN);
    // The counter holds the rises already taken, so the fall of clock k sees k-1.
    // Comparing against the clock numbers directly would skip the first data fall.
    wire out_slot   = in_frame & lnk.sclk_fall & rw_r
                      & (cnt_r >= (`SER_DATA_FIRST - 5'd1))
                      & (cnt_r <= (`SER_DATA_LAST - 5'd1));
    wire frame_full = (cnt_r == `SER_FRAME_LEN);

    // Bit collection; chip select high restarts the frame.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r   <= 5'h00;
            shift_r <= 24'h000000;
        end else if (lnk.cs_n) begin
            cnt_r   <= 5'h00;
        end else if (take_bit) begin
            cnt_r   <= cnt_r + 5'h01;
            shift_r <= {lnk.serial_in, shift_r[23:1]};
        end
    end

    // Header capture after the eighth address bit; dummy bits just shift through.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_r <= 8'h00;
            rw_r   <= 1'b0;
        end else if (hdr_done) begin
            addr_r <= shift_r[23:16];
            rw_r   <= lnk.serial_in;
        end
    end

    // Requests: a read is fetched early so the byte is ready before the 17th fall.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_req_r <= 1'b0;
            wr_req_r <= 1'b0;
        end else begin
            rd_req_r <= hdr_done & lnk.serial_in;
            wr_req_r <= lnk.cs_rise & frame_full & ~rw_r;
        end
    end

    // Readback shifter, driven out on falling serial clock edges.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rbuf_r <= 8'h00;
            sdo_r  <= 1'b0;
        end else if (lnk.rd_valid) begin
            rbuf_r <= lnk.rd_data;
        end else if (out_slot) begin
            sdo_r  <= rbuf_r[0];
            rbuf_r <= {1'b0, rbuf_r[7:1]};
        end
    end

    // Output stays released for writes and between frames.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdo_oe_r <= 1'b0;
        end else if (lnk.cs_n | ~rw_r) begin
            sdo_oe_r <= 1'b0;
        end else if (out_slot) begin
            sdo_oe_r <= 1'b1;
        end
    end

    assign lnk.rd_req = rd_req_r;
    assign lnk.wr_req = wr_req_r;
    assign lnk.addr   = addr_r;
    assign lnk.wdata  = shift_r[23:16];
    assign lnk.serial_out    = sdo_r;
    assign lnk.sdo_oe = sdo_oe_r;

endmodule

`default_nettype wire

// ==== host_port_checker_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

// Pin checks for the host port; all of them stay quiet during reset.
module host_port_checker (
    // Clock and reset.
    input wire logic       SYS_CLK,
    input wire logic       SYS_RST,
    // Pins under watch.
    input wire logic       SERIAL_PARALLEL_SELECT,
    input wire logic       CS_N,
    input wire logic       SERIAL_OUT_OE,
    input wire logic [7:0] DATA_OUT,
    input wire logic       DATA_OE,
    input wire logic       READY_N,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic       INT_REQ,
    input wire logic       INT_N
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    // Completion answers the register pulse two cycles back and carries its data.
    ready_cause_a: assert property (
        $fell(READY_N) |-> $past(REG_RD, 2) || $past(REG_WR, 2)) else $error("stray ready");
    read_data_a: assert property (
        $fell(READY_N) && DATA_OE |-> DATA_OUT == $past(REG_RDATA, 1)) else $error("read data");
    oe_ready_a: assert property ($rose(DATA_OE) |-> !READY_N)
        else $error("bus driven early");
    // A released select quiets the request, bus, ready and serial enable outputs once the synchronisers have seen it.
    cs_idle_a: assert property (CS_N [*8] |-> !REG_RD && !REG_WR)
        else $error("access without select");
    bus_release_a: assert property (CS_N [*6] |-> !DATA_OE && READY_N)
        else $error("bus held");
    sdo_release_a: assert property (CS_N [*6] |-> !SERIAL_OUT_OE)
        else $error("serial out held");
    // A serial write waits for the select to rise.
    ser_commit_a: assert property (
        (SERIAL_PARALLEL_SELECT && !CS_N) [*6] |-> !REG_WR) else $error("early commit");
    pulse_once_a: assert property (REG_RD |=> !REG_RD && !REG_WR)
        else $error("long pulse");
    int_pin_a: assert property ($rose(INT_REQ) |=> $fell(INT_N))
        else $error("interrupt pin");

    // Main scenarios reached.
    cover property ($fell(READY_N) && DATA_OE);
    cover property ($rose(SERIAL_OUT_OE));
    cover property (REG_WR && SERIAL_PARALLEL_SELECT);
endmodule

bind host_access_port host_port_checker u_host_port_checker (.*);

`default_nettype wire

// ==== reg_file_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module reg_file_model (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Access from the port.
    input  wire logic       wr,
    input  wire logic       rd,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic [7:0]      rdata
);
    logic [7:0] mem_r [256];

    // Read data is good for one cycle only, then scrambles, so a late sample shows.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            if (wr) mem_r[addr] <= wdata;
            if (rd) rdata <= mem_r[addr];
            else rdata <= ~rdata;
        end
    end
endmodule

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        SYS_CLK = 1'b0, SYS_RST = 1'b1, SERIAL_PARALLEL_SELECT = 1'b0, CS_N = 1'b1;
    logic        SCLK = 1'b1, SERIAL_IN = 1'b0, ADDR_LATCH = 1'b0, INT_REQ = 1'b0;
    logic        READ_OR_DATA_STROBE_N = 1'b1, WRITE_OR_DIRECTION = 1'b1;
    logic [1:0]  HOST_TYPE_SELECT = 2'h0;
    logic [7:0]  ADDR = 8'h00, DATA_IN = 8'h00;
    logic        SERIAL_OUT, SERIAL_OUT_OE, DATA_OE, READY_N, REG_WR, REG_RD, INT_N;
    logic [7:0]  DATA_OUT, REG_ADDR, REG_WDATA, REG_RDATA;
    logic [31:0] seed = 32'h81e35c5d;
    logic [7:0]  shadow [256];
    int          errors = 0, checks = 0, cycles = 0;

    host_access_port u_host_access_port (.*);
    reg_file_model u_reg_file_model (.clk(SYS_CLK), .rst(SYS_RST), .wr(REG_WR), .rd(REG_RD),
        .addr(REG_ADDR), .wdata(REG_WDATA), .rdata(REG_RDATA));

    // Clock, and a cycle ceiling well above the planned run.
    always #2.5 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        return shadow[a];
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // One parallel access; outside the synchronous bus mode the address moves after the latch falls so a stale latch shows.
    task automatic par(input logic [1:0] m, input logic cs_n, input logic rd,
                       input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic ok);
        int n;
        n = 0;
        HOST_TYPE_SELECT <= m;
        CS_N <= cs_n;
        ADDR <= a;
        DATA_IN <= d;
        ADDR_LATCH <= 1'b1;
        WRITE_OR_DIRECTION <= (m == 2'h0) | rd;
        cyc(4);
        ADDR_LATCH <= 1'b0;
        cyc(10);
        if (m != 2'h3) ADDR <= ~a;
        if (m == 2'h0 && !rd) WRITE_OR_DIRECTION <= 1'b0;
        else READ_OR_DATA_STROBE_N <= 1'b0;
        @(negedge SYS_CLK);
        while (READY_N !== 1'b0 && n < 20) begin
            @(negedge SYS_CLK);
            n++;
        end
        ok = (n < 20);
        q = DATA_OUT;
        if (ok) chk({7'h0, DATA_OE}, {7'h0, rd});
        @(posedge SYS_CLK);
        READ_OR_DATA_STROBE_N <= 1'b1;
        WRITE_OR_DIRECTION <= 1'b1;
        DATA_IN <= ~d;
        CS_N <= 1'b1;
        cyc(8);
        chk({7'h0, READY_N}, 8'h01);
    endtask

    // One serial frame of nb bits at 125 ns per bit; the clock idles high between frames.
    task automatic ser(input logic rd, input logic [7:0] a, input logic [7:0] d,
                       input int nb, output logic [7:0] q);
        logic [23:0] f;
        f = {d, 7'(rnd()), rd, a};
        q = 8'h00;
        CS_N <= 1'b0;
        cyc(4);
        for (int i = 0; i < nb; i++) begin
            SCLK <= 1'b0;
            SERIAL_IN <= f[i];
            cyc(12);
            SCLK <= 1'b1;
            cyc(12);
            @(negedge SYS_CLK);
            if (i >= 16) begin
                q[i - 16] = SERIAL_OUT;
                chk({7'h0, SERIAL_OUT_OE}, {7'h0, rd});
            end
            @(posedge SYS_CLK);
        end
        SERIAL_IN <= ~SERIAL_IN;
        CS_N <= 1'b1;
        cyc(10);
    endtask

    // Main sequence: parallel modes, refusals, serial frames, interrupt pin.
    initial begin
        logic [7:0] a, d, q;
        logic [1:0] md;
        logic       ok;
        cyc(3);
        SYS_RST <= 1'b0;
        cyc(4);
        for (int j = 0; j < 3; j++) begin
            md = (j == 2) ? 2'h3 : 2'(j);
            for (int k = 0; k < 4; k++) begin
                a = (k == 0) ? 8'hff : rnd();
                d = rnd();
                par(md, 1'b0, 1'b0, a, d, q, ok);
                shadow[a] = d;
                chk({7'h0, ok}, 8'h01);
                par(md, 1'b0, 1'b1, a, 8'h00, q, ok);
                chk(q, exp_rd(a));
            end
            $display("Parallel mode %h done", md);
        end
        par(2'h0, 1'b1, 1'b0, a, ~d, q, ok);
        chk({7'h0, ok}, 8'h00);
        par(2'h2, 1'b0, 1'b0, a, ~d, q, ok);
        chk({7'h0, ok}, 8'h00);
        par(2'h0, 1'b0, 1'b1, a, 8'h00, q, ok);
        chk(q, exp_rd(a));
        $display("Refused accesses done");
        SERIAL_PARALLEL_SELECT <= 1'b1;
        cyc(8);
        for (int k = 0; k < 3; k++) begin
            a = rnd();
            d = rnd();
            ser(1'b0, a, d, 24, q);
            shadow[a] = d;
            ser(1'b1, a, 8'h00, 24, q);
            chk(q, exp_rd(a));
        end
        ser(1'b0, a, ~d, 20, q);
        ser(1'b1, a, 8'h00, 24, q);
        chk(q, exp_rd(a));
        $display("Serial frames done");
        for (int k = 0; k < 2; k++) begin
            INT_REQ <= ~INT_REQ;
            cyc(2);
            @(negedge SYS_CLK);
            chk({7'h0, INT_N}, {7'h0, ~INT_REQ});
            @(posedge SYS_CLK);
        end
        $display("Interrupt pin done");
        final_report();
    end
endmodule

`default_nettype wire
